// *** rtl/eecs_pkg.sv ***
// Shared constants and types for the EEPROM command sequencer
package eecs_pkg;
    // Command codes held in the high byte of command object entry 0
    localparam logic [7:0]  CMD_ERASE_VERIFY = 8'h10;
    localparam logic [7:0]  CMD_PROGRAM      = 8'h11;
    localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h12;
    // Command object index values expected at launch, first program data entry and entry count
    localparam logic [2:0]  IDX_ERASE_VERIFY = 3'h2;
    localparam logic [2:0]  IDX_PROG_MIN     = 3'h2;
    localparam logic [2:0]  IDX_PROG_MAX     = 3'h5;
    localparam logic [2:0]  IDX_SECTOR_ERASE = 3'h1;
    localparam logic [2:0]  IDX_PROG_DATA0   = 3'h2;
    localparam int          NUM_CCOB         = 6;
    // Global address bit that selects EEPROM over flash
    localparam int          GADDR_ARRAY_SEL  = 23;
    // Register byte offsets
    localparam logic [11:0] OFF_INDEX        = 12'h000;
    localparam logic [11:0] OFF_CMD_HI       = 12'h004;
    localparam logic [11:0] OFF_CMD_LO       = 12'h008;
    localparam logic [11:0] OFF_STATUS       = 12'h00c;
    localparam logic [11:0] OFF_PROT         = 12'h010;
    localparam logic [11:0] OFF_MODE         = 12'h014;
    // Status register bit positions
    localparam int          ST_DONE          = 7;
    localparam int          ST_ACC_ERR       = 5;
    localparam int          ST_PROT_VIOL     = 4;
    localparam int          ST_MG1           = 1;
    localparam int          ST_MG0           = 0;
    // Protection register layout
    localparam int          PROT_EN_BIT      = 16;
    // Reset values
    localparam logic        RST_MODE_OK      = 1'b1;
    localparam logic        RST_PROT_EN      = 1'b0;
    localparam logic [15:0] RST_PROT_BOUND   = 16'hffff;
    localparam logic [7:0]  RST_CCOB         = 8'h00;
    localparam logic [7:0]  ERASED_BYTE      = 8'hff;

    typedef enum logic [2:0] {
        EECS_IDLE,
        EECS_CHECK,
        EECS_WRITE,
        EECS_VRD,
        EECS_VCMP,
        EECS_DONE
    } eecs_state_t;
endpackage

// *** rtl/eecs_mem.sv ***
// EEPROM byte array with registered read data
`timescale 1ns/1ps
module eecs_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    logic [7:0] mem [DEPTH];

    // One cell per entry, erased at reset
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mem[i] <= eecs_pkg::ERASED_BYTE;
            end else if (wr_en && wr_addr == AW'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= eecs_pkg::ERASED_BYTE;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // eecs_mem

// *** rtl/eecs_check.sv ***
// Launch-time checks and operation extent for one command
`timescale 1ns/1ps
module eecs_check #(
    parameter int EE_BYTES = 256,
    parameter int SECTOR   = 4
) (
    input  wire logic [7:0]  code,
    input  wire logic [2:0]  index,
    input  wire logic [23:0] gaddr,
    input  wire logic [15:0] count,
    input  wire logic        mode_ok,
    input  wire logic        prot_en,
    input  wire logic [15:0] prot_bound,
    output logic             acc_err,
    output logic             prot_err,
    output logic      [15:0] first,
    output logic      [16:0] len
);
    localparam logic [23:0] SIZE  = 24'(EE_BYTES);
    localparam logic [23:0] SMASK = ~24'(SECTOR - 1);

    logic        is_ev;
    logic        is_pg;
    logic        is_se;
    logic [23:0] off;
    logic        in_ee;
    logic        idx_bad;
    logic [23:0] stop;
    logic [23:0] last;

    // Command decode and EEPROM offset
    assign is_ev   = code == eecs_pkg::CMD_ERASE_VERIFY;
    assign is_pg   = code == eecs_pkg::CMD_PROGRAM;
    assign is_se   = code == eecs_pkg::CMD_SECTOR_ERASE;
    assign off     = {1'b0, gaddr[22:0]};
    assign in_ee   = gaddr[eecs_pkg::GADDR_ARRAY_SEL] && off < SIZE;
    assign idx_bad = (is_ev && index != eecs_pkg::IDX_ERASE_VERIFY)
                   || (is_pg && (index < eecs_pkg::IDX_PROG_MIN || index > eecs_pkg::IDX_PROG_MAX))
                   || (is_se && index != eecs_pkg::IDX_SECTOR_ERASE);

    // Extent of the operation
    assign first = is_se ? off[15:0] & SMASK[15:0] : off[15:0];
    assign len   = is_ev ? {1'b0, count}
                 : is_pg ? {14'h0000, index - 3'h1}
                 : 17'(SECTOR);
    assign stop  = {8'h00, first} + {7'h00, len};
    assign last  = stop - 24'h000001;

    // Access error and protection outcome
    assign acc_err  = !mode_ok || !in_ee || idx_bad || !(is_ev || is_pg || is_se)
                    || ((is_ev || is_pg) && stop > SIZE);
    assign prot_err = prot_en && (is_pg || is_se) && last >= {8'h00, prot_bound};
endmodule // eecs_check

// *** rtl/eecs_sequencer.sv ***
// EEPROM command sequencer with APB register access
// Overview of operation
// - Erase verify: entry 0 code 0x10 and addr[23:16], entry 1 addr, entry 2 count.
// - Clearing complete flag launches erase verify; flag sets when check finishes.
// - Any non-blank byte in erase verify sets both verify status bits.
// - Erase verify launched with index other than 2 gives access error.
// - Erase verify with bad address or section past block end gives access error.
// - Erase verify read errors set verify bits; never sets protection violation.
// - Program code 0x11 writes one to four bytes then verifies each.
// - Program data sit at entries 2..5; index at launch sets byte count.
// - Program launched with index below 2 or above 5 gives access error.
// - Program group running past block end gives access error.
// - Program writes only unprotected area; protected target sets protection violation.
// - Program and sector erase verify errors set verify status bits.
// - Sector erase: code 0x12 and address anywhere inside the sector.
// - Sector erase erases every byte of the sector, verifies, sets complete flag.
// - Sector erase launched with index other than 1 gives access error.
// - Any command gives access error if mode forbids it or address invalid.
// - Protected sector erase sets protection violation and leaves the sector intact.
// - Global address bit 23 selects EEPROM when one, flash when zero.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module eecs_sequencer #(
    parameter int EE_BYTES = 256,
    parameter int SECTOR   = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    output logic             command_complete_flag
);
    localparam int AW = $clog2(EE_BYTES);

    logic [2:0]              command_object_index;
    logic [7:0]              command_object_high_byte [eecs_pkg::NUM_CCOB];
    logic [7:0]              command_object_low_byte  [eecs_pkg::NUM_CCOB];
    logic                    access_error_flag;
    logic                    protection_violation_flag;
    logic                    verify_status_bit1;
    logic                    verify_status_bit0;
    logic                    mode_ok;
    logic                    prot_en;
    logic [15:0]             prot_bound;
    eecs_pkg::eecs_state_t   state;
    eecs_pkg::eecs_state_t   next_state;
    logic [7:0]              cmd_code;
    logic [15:0]             first;
    logic [16:0]             len;
    logic [16:0]             ptr;
    logic [16:0]             next_ptr;

    // Bus decode
    logic        acc;
    logic        wr;
    logic        hit_idx;
    logic        hit_hi;
    logic        hit_lo;
    logic        hit_st;
    logic        hit_prot;
    logic        hit_mode;
    logic        mapped;
    logic        idle_wr;
    logic        idx_ok;
    logic [7:0]  status_byte;
    logic [31:0] rd_mux;

    assign acc      = psel && penable && pready;
    assign wr       = acc && pwrite;
    assign hit_idx  = paddr == eecs_pkg::OFF_INDEX;
    assign hit_hi   = paddr == eecs_pkg::OFF_CMD_HI;
    assign hit_lo   = paddr == eecs_pkg::OFF_CMD_LO;
    assign hit_st   = paddr == eecs_pkg::OFF_STATUS;
    assign hit_prot = paddr == eecs_pkg::OFF_PROT;
    assign hit_mode = paddr == eecs_pkg::OFF_MODE;
    assign mapped   = hit_idx || hit_hi || hit_lo || hit_st || hit_prot || hit_mode;
    assign idle_wr  = wr && command_complete_flag;
    assign idx_ok   = command_object_index < 3'(eecs_pkg::NUM_CCOB);

    // Read data selection
    assign status_byte = {command_complete_flag, 1'b0, access_error_flag, protection_violation_flag,
                          2'b00, verify_status_bit1, verify_status_bit0};
    assign rd_mux = hit_idx  ? {29'h0, command_object_index}
                  : hit_hi   ? {24'h0, idx_ok ? command_object_high_byte[command_object_index] : 8'h00}
                  : hit_lo   ? {24'h0, idx_ok ? command_object_low_byte[command_object_index] : 8'h00}
                  : hit_st   ? {24'h0, status_byte}
                  : hit_prot ? {15'h0, prot_en, prot_bound}
                  : hit_mode ? {31'h0, mode_ok}
                  : 32'h0;

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Index, protection and mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_object_index <= 3'h0;
            prot_en              <= eecs_pkg::RST_PROT_EN;
            prot_bound           <= eecs_pkg::RST_PROT_BOUND;
            mode_ok              <= eecs_pkg::RST_MODE_OK;
        end else if (idle_wr) begin
            if (hit_idx) command_object_index <= pwdata[2:0];
            if (hit_prot) prot_en <= pwdata[eecs_pkg::PROT_EN_BIT];
            if (hit_prot) prot_bound <= pwdata[15:0];
            if (hit_mode) mode_ok <= pwdata[0];
        end
    end

    // Command object entries, written through the index
    for (genvar i = 0; i < eecs_pkg::NUM_CCOB; i++) begin : g_ccob
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                command_object_high_byte[i] <= eecs_pkg::RST_CCOB;
                command_object_low_byte[i]  <= eecs_pkg::RST_CCOB;
            end else if (idle_wr && command_object_index == 3'(i)) begin
                if (hit_hi) command_object_high_byte[i] <= pwdata[7:0];
                if (hit_lo) command_object_low_byte[i] <= pwdata[7:0];
            end
        end
    end

    // Launch-time checks
    logic        chk_acc;
    logic        chk_pv;
    logic [15:0] chk_first;
    logic [16:0] chk_len;

    eecs_check #(
        .EE_BYTES (EE_BYTES),
        .SECTOR   (SECTOR)
    ) u_check (
        .code       (command_object_high_byte[0]),
        .index      (command_object_index),
        .gaddr      ({command_object_low_byte[0], command_object_high_byte[1], command_object_low_byte[1]}),
        .count      ({command_object_high_byte[2], command_object_low_byte[2]}),
        .mode_ok    (mode_ok),
        .prot_en    (prot_en),
        .prot_bound (prot_bound),
        .acc_err    (chk_acc),
        .prot_err   (chk_pv),
        .first      (chk_first),
        .len        (chk_len)
    );

    // Sequencer control terms
    logic          launch;
    logic          st_check;
    logic          st_write;
    logic          st_vcmp;
    logic          last_byte;
    logic          chk_fail;
    logic          mismatch;
    logic [7:0]    prog_byte;
    logic [7:0]    expect_byte;
    logic          mem_we;
    logic          mem_re;
    logic [AW-1:0] mem_addr;
    logic [7:0]    mem_wdata;
    logic [7:0]    mem_rdata;

    assign launch      = idle_wr && hit_st && pwdata[eecs_pkg::ST_DONE]
                         && !access_error_flag && !protection_violation_flag;
    assign st_check    = state == eecs_pkg::EECS_CHECK;
    assign st_write    = state == eecs_pkg::EECS_WRITE;
    assign st_vcmp     = state == eecs_pkg::EECS_VCMP;
    assign last_byte   = ptr + 17'h00001 == len;
    assign chk_fail    = chk_acc || chk_pv;
    assign prog_byte   = command_object_low_byte[3'(ptr[1:0]) + eecs_pkg::IDX_PROG_DATA0];
    assign expect_byte = cmd_code == eecs_pkg::CMD_PROGRAM ? prog_byte : eecs_pkg::ERASED_BYTE;
    assign mismatch    = st_vcmp && mem_rdata != expect_byte;
    assign mem_we      = st_write;
    assign mem_re      = state == eecs_pkg::EECS_VRD;
    assign mem_addr    = AW'(first + ptr[15:0]);
    assign mem_wdata   = cmd_code == eecs_pkg::CMD_SECTOR_ERASE ? eecs_pkg::ERASED_BYTE : prog_byte;

    // Next state and byte pointer
    always_comb begin
        next_state = state;
        next_ptr   = ptr;
        case (state)
            eecs_pkg::EECS_IDLE: begin
                if (launch) next_state = eecs_pkg::EECS_CHECK;
            end
            eecs_pkg::EECS_CHECK: begin
                next_ptr = 17'h00000;
                if (chk_fail || chk_len == 17'h00000) begin
                    next_state = eecs_pkg::EECS_DONE;
                end else if (command_object_high_byte[0] == eecs_pkg::CMD_ERASE_VERIFY) begin
                    next_state = eecs_pkg::EECS_VRD;
                end else begin
                    next_state = eecs_pkg::EECS_WRITE;
                end
            end
            eecs_pkg::EECS_WRITE: begin
                next_ptr = last_byte ? 17'h00000 : ptr + 17'h00001;
                if (last_byte) next_state = eecs_pkg::EECS_VRD;
            end
            eecs_pkg::EECS_VRD: begin
                next_state = eecs_pkg::EECS_VCMP;
            end
            eecs_pkg::EECS_VCMP: begin
                next_ptr   = ptr + 17'h00001;
                next_state = last_byte ? eecs_pkg::EECS_DONE : eecs_pkg::EECS_VRD;
            end
            eecs_pkg::EECS_DONE: begin
                next_state = eecs_pkg::EECS_IDLE;
            end
            default: begin
                next_state = eecs_pkg::EECS_IDLE;
            end
        endcase
    end

    // Sequencer registers, extent captured at the check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= eecs_pkg::EECS_IDLE;
            ptr      <= 17'h00000;
            cmd_code <= 8'h00;
            first    <= 16'h0000;
            len      <= 17'h00000;
        end else begin
            state <= next_state;
            ptr   <= next_ptr;
            if (st_check) begin
                cmd_code <= command_object_high_byte[0];
                first    <= chk_first;
                len      <= chk_len;
            end
        end
    end

    // Status flag next values; hardware set wins over software clear
    logic next_done_flag;
    logic next_acc_err;
    logic next_prot_viol;
    logic next_mg1;
    logic next_mg0;
    logic clr_acc;
    logic clr_pv;

    assign clr_acc        = idle_wr && hit_st && pwdata[eecs_pkg::ST_ACC_ERR];
    assign clr_pv         = idle_wr && hit_st && pwdata[eecs_pkg::ST_PROT_VIOL];
    assign next_done_flag = (state == eecs_pkg::EECS_DONE) || (command_complete_flag && !launch);
    assign next_acc_err   = (st_check && chk_acc) || (access_error_flag && !clr_acc);
    assign next_prot_viol = (st_check && !chk_acc && chk_pv) || (protection_violation_flag && !clr_pv);
    assign next_mg1    = mismatch || (verify_status_bit1 && !launch);
    assign next_mg0    = mismatch || (verify_status_bit0 && !launch);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_complete_flag     <= 1'b1;
            access_error_flag         <= 1'b0;
            protection_violation_flag <= 1'b0;
            verify_status_bit1        <= 1'b0;
            verify_status_bit0        <= 1'b0;
        end else begin
            command_complete_flag     <= next_done_flag;
            access_error_flag         <= next_acc_err;
            protection_violation_flag <= next_prot_viol;
            verify_status_bit1        <= next_mg1;
            verify_status_bit0        <= next_mg0;
        end
    end

    // EEPROM array
    eecs_mem #(
        .DEPTH (EE_BYTES),
        .AW    (AW)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (mem_we),
        .wr_addr (mem_addr),
        .wr_data (mem_wdata),
        .rd_en   (mem_re),
        .rd_addr (mem_addr),
        .rd_data (mem_rdata)
    );

    // Checks on sequencing
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    launch_clears_flag_a: assert property (launch |=> !command_complete_flag && st_check)
        else $error("launch did not clear complete flag");
    abort_no_write_a: assert property (st_check && chk_fail |=> !mem_we ##1 (!mem_we && command_complete_flag))
        else $error("failed check touched array or did not complete");
    bad_index_acc_a: assert property (st_check && command_object_high_byte[0] == eecs_pkg::CMD_SECTOR_ERASE
        && command_object_index != eecs_pkg::IDX_SECTOR_ERASE |=> access_error_flag)
        else $error("sector erase bad index missed access error");
    blank_fail_both_a: assert property (st_vcmp && cmd_code == eecs_pkg::CMD_ERASE_VERIFY
        && mem_rdata != eecs_pkg::ERASED_BYTE |=> verify_status_bit1 && verify_status_bit0)
        else $error("blank check failure did not set both bits");
    verify_no_pviol_a: assert property (!command_complete_flag && cmd_code == eecs_pkg::CMD_ERASE_VERIFY
        && !st_check |-> !protection_violation_flag)
        else $error("erase verify raised protection violation");
    prot_blocks_write_a: assert property (st_check && !chk_acc && chk_pv |=> protection_violation_flag
        && !mem_we ##1 !mem_we)
        else $error("protected target not flagged or written");
    erase_writes_ff_a: assert property (mem_we && cmd_code == eecs_pkg::CMD_SECTOR_ERASE
        |-> mem_wdata == eecs_pkg::ERASED_BYTE)
        else $error("sector erase wrote non-erased data");
    write_then_verify_a: assert property (st_write && last_byte |=> mem_re ##1 st_vcmp)
        else $error("write phase not followed by verify");
    out_of_ee_acc_a: assert property (st_check
        && !command_object_low_byte[0][7] |=> access_error_flag)
        else $error("flash address not refused");

    cover_verify_c:  cover property (st_check && !chk_fail && command_object_high_byte[0] == eecs_pkg::CMD_ERASE_VERIFY);
    cover_program_c: cover property (st_write && cmd_code == eecs_pkg::CMD_PROGRAM && last_byte);
    cover_erase_c:   cover property (st_vcmp && cmd_code == eecs_pkg::CMD_SECTOR_ERASE && last_byte);
    cover_pviol_c:   cover property (st_check && !chk_acc && chk_pv);
endmodule // eecs_sequencer

// *** verification/eeprom_command_sequencer_tb_top.sv ***
// Self-checking bench for the EEPROM command sequencer
`timescale 1ns/1ps
module eeprom_command_sequencer_tb_top;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        command_complete_flag;
    logic [32:0] expq[$];
    logic [32:0] want;
    logic [31:0] seed     = 32'h0b5f;
    int          failures = 0;
    int          compares = 0;

    eecs_sequencer DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .command_complete_flag(command_complete_flag)
    );

    // Bus clock, 8 ns period
    always #4 pclk = ~pclk;

    // Xorshift source for program data
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("counts: compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic tmo();
        failures++;
        $display("ERROR t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        results();
    endtask

    // Read monitor: oldest noted result against error flag and read data
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            want = (expq.size() > 0) ? expq.pop_front() : 33'h1ffffffff;
            chk({pslverr, prdata}, want);
        end
    end

    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        if (!w) expq.push_back(e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic ent(input logic [2:0] i, input logic [7:0] hi, input logic [7:0] lo);
        wr(eecs_pkg::OFF_INDEX, {29'h0, i});
        wr(eecs_pkg::OFF_CMD_HI, {24'h0, hi});
        wr(eecs_pkg::OFF_CMD_LO, {24'h0, lo});
    endtask

    // Load, launch, await and check one command; k 0 verify, 1 program, 2 sector erase
    task automatic cmd(input logic [1:0] k, input logic [23:0] ga, input logic [15:0] cnt, input logic [2:0] ix,
                       input logic [7:0] st, input logic poke);
        int n;
        logic p;
        p = (k == 2'd1);
        ent(3'h0, (k == 2'd0) ? eecs_pkg::CMD_ERASE_VERIFY : p ? eecs_pkg::CMD_PROGRAM : eecs_pkg::CMD_SECTOR_ERASE,
            ga[23:16]);
        ent(3'h1, ga[15:8], ga[7:0]);
        for (int i = 2; i < 6; i++) begin
            seed = xs(seed);
            ent(i[2:0], p ? 8'h00 : cnt[15:8], p ? (seed[7:0] & 8'hfe) : cnt[7:0]);
        end
        wr(eecs_pkg::OFF_INDEX, {29'h0, ix});
        wr(eecs_pkg::OFF_STATUS, 32'h80);
        if (poke) wr(eecs_pkg::OFF_INDEX, 32'h0);
        else @(posedge pclk);
        chk({32'h0, command_complete_flag}, 33'h0);
        n = 0;
        while (command_complete_flag !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) tmo();
        rd(eecs_pkg::OFF_STATUS, {24'h0, st});
        rd(eecs_pkg::OFF_INDEX, {29'h0, ix});
        wr(eecs_pkg::OFF_STATUS, 32'h30);
        $display("test kind %0d addr %h done", k, ga);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(eecs_pkg::OFF_INDEX, 32'h0);
        rd(eecs_pkg::OFF_STATUS, 32'h80);
        rd(eecs_pkg::OFF_PROT, 32'h0000ffff);
        rd(eecs_pkg::OFF_MODE, 32'h1);
        rd(eecs_pkg::OFF_CMD_HI, 32'h0);
        apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
        $display("test reset values done");
        cmd(2'd0, 24'h800020, 16'h8, 3'h2, 8'h80, 1'b0);
        cmd(2'd1, 24'h800010, 16'h0, 3'h5, 8'h80, 1'b0);
        cmd(2'd0, 24'h800010, 16'h4, 3'h2, 8'h83, 1'b0);
        cmd(2'd1, 24'h800030, 16'h0, 3'h2, 8'h80, 1'b0);
        cmd(2'd0, 24'h800031, 16'h3, 3'h2, 8'h80, 1'b0);
        cmd(2'd0, 24'h800030, 16'h1, 3'h2, 8'h83, 1'b0);
        cmd(2'd2, 24'h800012, 16'h0, 3'h1, 8'h80, 1'b1);
        cmd(2'd0, 24'h800010, 16'h4, 3'h2, 8'h80, 1'b0);
        cmd(2'd0, 24'h800020, 16'h8, 3'h3, 8'ha0, 1'b0);
        cmd(2'd0, 24'h8000fc, 16'h8, 3'h2, 8'ha0, 1'b0);
        cmd(2'd0, 24'h000020, 16'h8, 3'h2, 8'ha0, 1'b0);
        cmd(2'd1, 24'h800040, 16'h0, 3'h1, 8'ha0, 1'b0);
        cmd(2'd1, 24'h800040, 16'h0, 3'h6, 8'ha0, 1'b0);
        cmd(2'd1, 24'h8000fe, 16'h0, 3'h5, 8'ha0, 1'b0);
        cmd(2'd2, 24'h800040, 16'h0, 3'h2, 8'ha0, 1'b0);
        wr(eecs_pkg::OFF_MODE, 32'h0);
        cmd(2'd2, 24'h800040, 16'h0, 3'h1, 8'ha0, 1'b0);
        wr(eecs_pkg::OFF_MODE, 32'h1);
        cmd(2'd1, 24'h800040, 16'h0, 3'h2, 8'h80, 1'b0);
        wr(eecs_pkg::OFF_PROT, 32'h00010040);
        cmd(2'd1, 24'h800090, 16'h0, 3'h2, 8'h90, 1'b0);
        cmd(2'd0, 24'h800090, 16'h1, 3'h2, 8'h80, 1'b0);
        cmd(2'd2, 24'h800041, 16'h0, 3'h1, 8'h90, 1'b0);
        cmd(2'd0, 24'h800040, 16'h1, 3'h2, 8'h83, 1'b0);
        results();
    end
endmodule // eeprom_command_sequencer_tb_top
